// ### hw/frt_regs.svh
// frt_regs.svh: addresses, bit positions and timing counts of the timer.
// assumes byte-wide register access at the documented addresses.
`ifndef FRT_REGS_SVH
`define FRT_REGS_SVH

`define FRT_A_CTRL  8'h12
`define FRT_A_STAT  8'h13
`define FRT_A_CAPH  8'h14
`define FRT_A_CAPL  8'h15
`define FRT_A_CMPH  8'h16
`define FRT_A_CMPL  8'h17
`define FRT_A_CNTH  8'h18
`define FRT_A_CNTL  8'h19
`define FRT_A_ALTH  8'h1A
`define FRT_A_ALTL  8'h1B

// enables in control and flags in status share bit positions
`define FRT_B_CAP   7
`define FRT_B_CMP   6
`define FRT_B_OVF   5

`define FRT_CNT_RST 16'hFFFC
`define FRT_CNT_MAX 16'hFFFF
`define FRT_PRESCALE 4
`define FRT_OSC_DLY  4064

`endif

// ### hw/frt_pkg.sv
// frt_pkg: state types of the free-running timer.
// assumes nothing beyond the register header.
package frt_pkg;

    typedef enum logic [0:0] {
        FRT_WAIT = 1'b0,
        FRT_RUN  = 1'b1
    } frt_cnt_mode_t;

    typedef struct packed {
        frt_cnt_mode_t mode;
        logic [11:0]   dly;
        logic [7:0]    phase;
        logic [15:0]   count;
        logic          tick;
        logic          wrap;
    } frt_cnt_state_t;

    typedef struct packed {
        logic [2:0]  en;
        logic        capture_flag;
        logic        compare_flag;
        logic        overflow_flag;
        logic        ica;
        logic        oca;
        logic        toa;
        logic [15:0] cap;
        logic        cap_inh;
        logic [15:0] cmp;
        logic        cmp_inh;
        logic [7:0]  buf8;
        logic        bufv;
        logic        restart;
        logic [7:0]  rdata;
        logic        irq;
    } frt_state_t;

endpackage

// ### hw/frt_cnt_if.sv
// frt_cnt_if: link between the register logic and the counter core.
// assumes both ends share clk_i.
`timescale 1ns/1ps
`default_nettype none

interface frt_cnt_if;
    logic        restart;
    logic        tick;
    logic        wrap;
    logic [15:0] count;

    modport cnt (input restart, output tick, output wrap, output count);
    modport ctl (output restart, input tick, input wrap, input count);
endinterface

`default_nettype wire

// ### hw/frt_counter.sv
// frt_counter: 16-bit free-running counter behind a fixed prescaler.
// assumes clk_i is the internal bus clock; restart is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
`include "frt_regs.svh"

module frt_counter
    import frt_pkg::*;
#(
    parameter int PRESCALE = `FRT_PRESCALE,
    parameter int OSC_DLY  = `FRT_OSC_DLY
) (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    frt_cnt_if.cnt      cb
);

    // phase and delay counters are 8 and 12 bits wide
    if (PRESCALE < 2 || PRESCALE > 256 || OSC_DLY < 1 || OSC_DLY > 4095) begin : g_bad_param
        $error("frt_counter: parameter out of range");
    end

    localparam logic [7:0]  PH_LAST  = 8'(PRESCALE - 1);
    localparam logic [11:0] DLY_LAST = 12'(OSC_DLY - 1);

    frt_cnt_state_t s_reg;
    frt_cnt_state_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        s_next.wrap = 1'b0;
        case (s_reg.mode)
            FRT_WAIT: begin
                // preset value held through oscillator start-up
                s_next.dly = s_reg.dly + 12'h001;
                if (s_reg.dly == DLY_LAST) begin
                    s_next.mode = FRT_RUN;
                end
            end
            FRT_RUN: begin
                s_next.phase = s_reg.phase + 8'h01;
                // bus clock low phase is modelled as the last prescaler slot
                if (s_reg.phase == PH_LAST) begin
                    s_next.phase = 8'h00;
                    s_next.count = s_reg.count + 16'h0001;
                    s_next.tick  = 1'b1;
                    s_next.wrap  = (s_reg.count == `FRT_CNT_MAX);
                end
            end
            default: begin
                s_next.mode = FRT_WAIT;
            end
        endcase
        if (cb.restart) begin
            s_next.count = `FRT_CNT_RST;
            s_next.phase = 8'h00;
            s_next.tick  = 1'b0;
            s_next.wrap  = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_reg <= '{mode: FRT_WAIT, dly: 12'h000, phase: 8'h00,
                       count: `FRT_CNT_RST, tick: 1'b0, wrap: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign cb.count = s_reg.count;
    assign cb.tick  = s_reg.tick;
    assign cb.wrap  = s_reg.wrap;

endmodule

`default_nettype wire

// ### hw/frt_timer.sv
// frt_timer: register file, flags and read buffering of the free-running timer.
// assumes a byte-wide processor port; rd_i/wr_i are one-cycle strobes.
`timescale 1ns/1ps
`default_nettype none
`include "frt_regs.svh"

// How it works
// - 16-bit counter, bus clock divided by four
// - reset preset FFFC; reads never disturb count
// - power-on: hold preset until oscillator delay
// - count steps in bus clock low phase
// - wrap from all-ones sets overflow flag
// - status read then counter low read clears overflow
// - alternate counter reads never clear overflow
// - status read then capture low access clears capture
// - compare match sets flag; status+compare-low clears
// - three enables, all cleared by reset
// - overflow interrupt only with bit 5 enable
// - ten byte registers at 12 to 1B
// - high access inhibits function until low access
// - lone low read returns live count
// - high read buffers low byte, frozen
// - low write reloads FFFC, resets prescaler
// - reload ends pending buffered read sequence
module frt_timer
    import frt_pkg::*;
#(
    parameter int PRESCALE = `FRT_PRESCALE,
    parameter int OSC_DLY  = `FRT_OSC_DLY
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       rd_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       capture_i,
    output logic      [7:0] rdata_o,
    output logic            irq_o
);

    frt_cnt_if cb ();

    frt_counter #(
        .PRESCALE (PRESCALE),
        .OSC_DLY  (OSC_DLY)
    ) u_counter (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .cb      (cb)
    );

    frt_state_t s_reg;
    frt_state_t s_next;

    logic rd_stat;
    logic acc_capl;
    logic rd_caph;
    logic acc_cmpl;
    logic wr_cmph;
    logic rd_cntl;
    logic rd_hi;
    logic rd_lo;
    logic wr_lo;
    logic cmp_hit;

    always_comb begin
        rd_stat  = rd_i && (addr_i == `FRT_A_STAT);
        rd_caph  = rd_i && (addr_i == `FRT_A_CAPH);
        acc_capl = (rd_i || wr_i) && (addr_i == `FRT_A_CAPL);
        wr_cmph  = wr_i && (addr_i == `FRT_A_CMPH);
        acc_cmpl = (rd_i || wr_i) && (addr_i == `FRT_A_CMPL);
        rd_cntl  = rd_i && (addr_i == `FRT_A_CNTL);
        rd_hi    = rd_i && (addr_i == `FRT_A_CNTH || addr_i == `FRT_A_ALTH);
        rd_lo    = rd_i && (addr_i == `FRT_A_CNTL || addr_i == `FRT_A_ALTL);
        wr_lo    = wr_i && (addr_i == `FRT_A_CNTL || addr_i == `FRT_A_ALTL);
        // compare sampled once per count step, so a cleared flag is not
        // set again while the count rests on the matching value
        cmp_hit  = cb.tick && !s_reg.cmp_inh && (cb.count == s_reg.cmp);
    end

    always_comb begin
        s_next         = s_reg;
        s_next.restart = wr_lo;

        // read data; unmapped addresses answer zero
        if (rd_i) begin
            case (addr_i)
                `FRT_A_CTRL: s_next.rdata = {s_reg.en, 5'h00};
                `FRT_A_STAT: s_next.rdata = {s_reg.capture_flag, s_reg.compare_flag, s_reg.overflow_flag, 5'h00};
                `FRT_A_CAPH: s_next.rdata = s_reg.cap[15:8];
                `FRT_A_CAPL: s_next.rdata = s_reg.cap[7:0];
                `FRT_A_CMPH: s_next.rdata = s_reg.cmp[15:8];
                `FRT_A_CMPL: s_next.rdata = s_reg.cmp[7:0];
                `FRT_A_CNTH,
                `FRT_A_ALTH: s_next.rdata = cb.count[15:8];
                `FRT_A_CNTL,
                `FRT_A_ALTL: begin
                    s_next.rdata = s_reg.bufv ? s_reg.buf8 : cb.count[7:0];
                end
                default: s_next.rdata = 8'h00;
            endcase
        end

        // control writes
        if (wr_i && addr_i == `FRT_A_CTRL) begin
            s_next.en = wdata_i[`FRT_B_CAP:`FRT_B_OVF];
        end

        // counter buffering
        if (rd_hi && !s_reg.bufv) begin
            s_next.buf8 = cb.count[7:0];
            s_next.bufv = 1'b1;
        end
        if (rd_lo || wr_lo) begin
            s_next.bufv = 1'b0;
        end

        // compare register pair
        if (wr_cmph) begin
            s_next.cmp[15:8] = wdata_i;
            s_next.cmp_inh   = 1'b1;
        end
        if (wr_i && addr_i == `FRT_A_CMPL) begin
            s_next.cmp[7:0] = wdata_i;
            s_next.cmp_inh  = 1'b0;
        end

        // capture register pair
        if (rd_caph) begin
            s_next.cap_inh = 1'b1;
        end
        if (acc_capl) begin
            s_next.cap_inh = 1'b0;
        end

        // first step of each clearing sequence
        if (rd_stat) begin
            s_next.ica = s_reg.ica | s_reg.capture_flag;
            s_next.oca = s_reg.oca | s_reg.compare_flag;
            s_next.toa = s_reg.toa | s_reg.overflow_flag;
        end

        // second step; only the primary counter low byte clears overflow
        if (acc_capl && s_reg.ica) begin
            s_next.capture_flag = 1'b0;
            s_next.ica = 1'b0;
        end
        if (acc_cmpl && s_reg.oca) begin
            s_next.compare_flag = 1'b0;
            s_next.oca = 1'b0;
        end
        if (rd_cntl && s_reg.toa) begin
            s_next.overflow_flag = 1'b0;
            s_next.toa = 1'b0;
        end

        // events last: a set in the clearing cycle wins
        if (capture_i) begin
            s_next.capture_flag = 1'b1;
            if (!s_reg.cap_inh) begin
                s_next.cap = cb.count;
            end
        end
        if (cmp_hit) begin
            s_next.compare_flag = 1'b1;
        end
        if (cb.wrap) begin
            s_next.overflow_flag = 1'b1;
        end

        s_next.irq = |({s_next.capture_flag, s_next.compare_flag, s_next.overflow_flag} & s_next.en);
    end

    // flags, capture and compare have no defined reset state; zero keeps
    // simulation clean and software must still initialise them
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cb.restart = s_reg.restart;
    assign rdata_o    = s_reg.rdata;
    assign irq_o      = s_reg.irq;

    default clocking dc @(posedge clk_i);
    endclocking

    default disable iff (!rst_n_i);

    property p_reset_state;
        disable iff (1'b0)
        !rst_n_i |=> (s_reg.en == 3'b000) && (cb.count == `FRT_CNT_RST) && !irq_o;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

    property p_prescale;
        cb.tick |=> !cb.tick [*3];
    endproperty
    a_prescale: assert property (p_prescale) else $error("count steps too often");

    property p_step;
        cb.tick |-> cb.count == $past(cb.count) + 16'h0001;
    endproperty
    a_step: assert property (p_step) else $error("count step not by one");

    property p_wrap_sets;
        cb.wrap |=> s_reg.overflow_flag;
    endproperty
    a_wrap_sets: assert property (p_wrap_sets) else $error("overflow not flagged");

    property p_tof_clear;
        (s_reg.toa && rd_i && addr_i == `FRT_A_CNTL && !cb.wrap) |=> !s_reg.overflow_flag;
    endproperty
    a_tof_clear: assert property (p_tof_clear) else $error("overflow not cleared");

    property p_alt_keeps;
        (s_reg.overflow_flag && rd_i && addr_i == `FRT_A_ALTL) |=> s_reg.overflow_flag;
    endproperty
    a_alt_keeps: assert property (p_alt_keeps) else $error("alternate read lost flag");

    property p_cmp_set;
        (cb.tick && !s_reg.cmp_inh && cb.count == s_reg.cmp) |=> s_reg.compare_flag;
    endproperty
    a_cmp_set: assert property (p_cmp_set) else $error("compare flag missed");

    property p_irq;
        ##1 irq_o == |({s_reg.capture_flag, s_reg.compare_flag, s_reg.overflow_flag} & s_reg.en);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request mismatch");

    // overflow enable is the lowest of the three enable bits
    property p_ovf_irq;
        (cb.wrap && s_reg.en[0] && !(wr_i && addr_i == `FRT_A_CTRL)) |=> irq_o;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow interrupt missing");

    property p_no_irq;
        (s_reg.en == 3'b000 && !(wr_i && addr_i == `FRT_A_CTRL)) |=> !irq_o;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("interrupt without enable");

    property p_restart;
        wr_i && addr_i == `FRT_A_ALTL |=> ##1 (cb.count == `FRT_CNT_RST) && !s_reg.bufv;
    endproperty
    a_restart: assert property (p_restart) else $error("reload failed");

    property p_buf_frozen;
        (s_reg.bufv && rd_hi) |=> $stable(s_reg.buf8) && s_reg.bufv;
    endproperty
    a_buf_frozen: assert property (p_buf_frozen) else $error("buffer not frozen");

    c_wrap:    cover property (cb.wrap);
    c_tof_clr: cover property (s_reg.toa && rd_cntl);
    c_buf_rd:  cover property (s_reg.bufv && rd_lo);
    c_cmp:     cover property (cmp_hit);

endmodule

`default_nettype wire

// ### bench/frt_timer_tb.sv
// frt_timer_tb: self-checking bench for the free-running timer register block.
// assumes the design checks itself with assertions; short start-up delay used here.
`timescale 1ns/1ps
`default_nettype none
`include "frt_regs.svh"

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, (a), (e)); end end

module frt_timer_tb;
    import frt_pkg::*;

    logic       clk_i     = 1'b0;
    logic       rst_n_i   = 1'b0;
    logic [7:0] addr_i    = 8'h00;
    logic       rd_i      = 1'b0;
    logic       wr_i      = 1'b0;
    logic [7:0] wdata_i   = 8'h00;
    logic       capture_i = 1'b0;
    logic [7:0] rdata_o;
    logic       irq_o;
    logic [7:0] v;
    int         n_fail    = 0;
    int         checked   = 0;

    always #2.5 clk_i = ~clk_i;

    // prescale kept at 4: the design's own timing checks assume it
    frt_timer #(.PRESCALE(4), .OSC_DLY(4)) u_dut (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .addr_i    (addr_i),
        .rd_i      (rd_i),
        .wr_i      (wr_i),
        .wdata_i   (wdata_i),
        .capture_i (capture_i),
        .rdata_o   (rdata_o),
        .irq_o     (irq_o)
    );

    // rdata_o is settled one edge after the strobe and holds until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        @(posedge clk_i);
        d = rdata_o;
    endtask

    // extra edge so a following write never reassigns wr_i in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic t_reset;
        rd(`FRT_A_CNTH, v); `CHK(v, 8'hFF)
        rd(`FRT_A_CNTL, v); `CHK(v, 8'hFC)
        rd(`FRT_A_STAT, v); `CHK(v, 8'h00)
        rd(`FRT_A_CTRL, v); `CHK(v, 8'h00)
        `CHK(irq_o, 1'b0)
        rd(8'h20, v); `CHK(v, 8'h00)
        rd(8'h11, v); `CHK(v, 8'h00)
        wr(`FRT_A_CTRL, 8'hFF);
        rd(`FRT_A_CTRL, v); `CHK(v, 8'hE0)
        wr(`FRT_A_CTRL, 8'h00);
    endtask

    task automatic t_buffer;
        wr(`FRT_A_CNTL, 8'h55);
        idle(2);
        rd(`FRT_A_CNTH, v); `CHK(v, 8'hFF)
        idle(40);
        rd(`FRT_A_CNTH, v); `CHK(v, 8'h00)
        // low byte still the one frozen by the first high read
        rd(`FRT_A_CNTL, v); `CHK(v, 8'hFC)
        // compare rests at zero after reset, so the wrap also matches it
        rd(`FRT_A_STAT, v); `CHK(v, 8'h60)
        `CHK(irq_o, 1'b0)
    endtask

    task automatic t_overflow;
        wr(`FRT_A_CTRL, 8'h20);
        idle(2);
        `CHK(irq_o, 1'b1)
        // arm the clear first so only the alternate location can be blamed
        rd(`FRT_A_STAT, v);
        rd(`FRT_A_ALTL, v);
        rd(`FRT_A_STAT, v); `CHK(v, 8'h60)
        wr(`FRT_A_ALTL, 8'h00);
        rd(`FRT_A_CTRL, v); `CHK(v, 8'h20)
        rd(`FRT_A_STAT, v); `CHK(v, 8'h60)
        idle(1);
        // reload lands two edges after the write, first step four cycles on
        rd(`FRT_A_ALTL, v); `CHK(v, 8'hFD)
        idle(30);
        rd(`FRT_A_STAT, v);
        rd(`FRT_A_CNTL, v);
        rd(`FRT_A_STAT, v); `CHK(v, 8'h40)
        idle(2);
        `CHK(irq_o, 1'b0)
    endtask

    task automatic t_capture;
        wr(`FRT_A_CTRL, 8'h80);
        capture_i <= 1'b1;
        @(posedge clk_i);
        capture_i <= 1'b0;
        idle(3);
        rd(`FRT_A_STAT, v); `CHK(v & 8'h80, 8'h80)
        `CHK(irq_o, 1'b1)
        rd(`FRT_A_CAPH, v);
        rd(`FRT_A_CAPL, v);
        rd(`FRT_A_STAT, v); `CHK(v & 8'h80, 8'h00)
        idle(2);
        `CHK(irq_o, 1'b0)
    endtask

    task automatic t_compare;
        wr(`FRT_A_CTRL, 8'h40);
        // nothing can interrupt the bench between the two halves
        wr(`FRT_A_CMPH, 8'h00);
        rd(`FRT_A_STAT, v);
        wr(`FRT_A_CMPL, 8'h08);
        wr(`FRT_A_CNTL, 8'h00);
        idle(60);
        rd(`FRT_A_STAT, v); `CHK(v & 8'h40, 8'h40)
        `CHK(irq_o, 1'b1)
        wr(`FRT_A_CMPL, 8'h08);
        // high byte alone must hold off the match
        wr(`FRT_A_CMPH, 8'h00);
        wr(`FRT_A_CNTL, 8'h00);
        idle(60);
        rd(`FRT_A_STAT, v); `CHK(v & 8'h40, 8'h00)
    endtask

    // enables and a pending overflow are live when reset hits
    task automatic t_mid_reset;
        wr(`FRT_A_CTRL, 8'hE0);
        rst_n_i <= 1'b0;
        idle(2);
        rst_n_i <= 1'b1;
        rd(`FRT_A_CTRL, v); `CHK(v, 8'h00)
        `CHK(irq_o, 1'b0)
        rd(`FRT_A_CNTH, v); `CHK(v, 8'hFF)
    endtask

    task automatic stop_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        idle(12);
        rst_n_i <= 1'b1;
        t_reset();
        t_buffer();
        t_overflow();
        t_capture();
        t_compare();
        t_mid_reset();
        stop_test();
    end

    // whole run is well under a thousand cycles
    initial begin
        #25000;
        n_fail++;
        stop_test();
    end
endmodule

`default_nettype wire
